// [rtl/slpcg_mode_dec.sv]
// Combinational decode of a sleep mode into clock enables.
// Assumes the mode code comes from the core's registered selection.
`timescale 1ns/1ps
module slpcg_mode_dec (
  input  wire logic [2:0] mode,      // Selected sleep mode
  output logic      [8:0] ce,        // Clock enables while asleep
  output logic            valid      // Mode code is a defined mode
);

  always_comb begin
    ce    = '0;
    valid = 1'b1;
    case (mode)
      slpcg_pkg::MODE_IDLE: begin
        ce[slpcg_pkg::CE_SRAM] = 1'b1;
        ce[slpcg_pkg::CE_TMR]  = 1'b1;
        ce[slpcg_pkg::CE_SPI]  = 1'b1;
        ce[slpcg_pkg::CE_IRQ]  = 1'b1;
        ce[slpcg_pkg::CE_OSC]  = 1'b1;
        ce[slpcg_pkg::CE_ADC]  = 1'b1;
        ce[slpcg_pkg::CE_ASY]  = 1'b1;
        ce[slpcg_pkg::CE_IO]   = 1'b1;
      end
      slpcg_pkg::MODE_ADC_NR: begin
        ce[slpcg_pkg::CE_ASY] = 1'b1;
        ce[slpcg_pkg::CE_ADC] = 1'b1;
        ce[slpcg_pkg::CE_OSC] = 1'b1;
      end
      slpcg_pkg::MODE_PWR_DN: ce = '0;
      slpcg_pkg::MODE_PWR_SV: ce[slpcg_pkg::CE_ASY] = 1'b1;
      slpcg_pkg::MODE_STBY: ce[slpcg_pkg::CE_OSC] = 1'b1;
      slpcg_pkg::MODE_EXT_STB: begin
        ce[slpcg_pkg::CE_OSC] = 1'b1;
        ce[slpcg_pkg::CE_ASY] = 1'b1;
      end
      default: valid = 1'b0;
    endcase
  end

endmodule : slpcg_mode_dec

// [rtl/slpcg_pkg.sv]
// Constants for the sleep-mode clock gating controller.
// Assumes one 100 MHz core clock and a synchronous active-low reset.
// Overview of operation
// - Six software-selectable sleep modes
// - Idle: CPU stops, SRAM/timers/SPI/IRQ run
// - Power-down: oscillator stops, only IRQ/reset wake
// - Power-save: asynchronous timer keeps running
// - ADC noise: only async timer, ADC and main oscillator run
// - Standby: main oscillator runs, rest sleeps
// - Extended standby: oscillator and async timer run
package slpcg_pkg;

  // ****************************************************************
  // Mode encodings
  // ****************************************************************
  localparam logic [2:0] MODE_IDLE    = 3'h0;
  localparam logic [2:0] MODE_ADC_NR  = 3'h1;
  localparam logic [2:0] MODE_PWR_DN  = 3'h2;
  localparam logic [2:0] MODE_PWR_SV  = 3'h3;
  localparam logic [2:0] MODE_STBY    = 3'h6;
  localparam logic [2:0] MODE_EXT_STB = 3'h7;

  // ****************************************************************
  // Clock enable vector field positions
  // ****************************************************************
  localparam int CE_CPU   = 0;
  localparam int CE_SRAM  = 1;
  localparam int CE_TMR   = 2;
  localparam int CE_SPI   = 3;
  localparam int CE_IRQ   = 4;
  localparam int CE_ASY   = 5;
  localparam int CE_ADC   = 6;
  localparam int CE_OSC   = 7;
  localparam int CE_IO    = 8;
  localparam int CE_W     = 9;

  localparam logic [8:0] CE_ALL_ON  = 9'h1FF;
  localparam logic [8:0] CE_RST_VAL = 9'h1FF;

endpackage : slpcg_pkg

// [rtl/slpcg_top.sv]
// Sleep controller: enters the chosen mode on a sleep request and
// gates clock domains until an interrupt or reset wakes the device.
// Assumes sleep_req, sleep_en, mode_sel come from the core clock domain;
// ext_irq_b arrives from pins and is synchronised here.
`timescale 1ns/1ps
module slpcg_top (
  input  wire logic       core_clk,    // 100 MHz system clock
  input  wire logic       rst_b,       // Synchronous reset, active low
  input  wire logic       sleep_en,    // Sleep enable from core
  input  wire logic [2:0] mode_sel,    // Sleep mode select from core
  input  wire logic       sleep_req,   // One-cycle sleep instruction pulse
  input  wire logic       irq_pend,    // Internal interrupt pending
  input  wire logic       ext_irq_b,   // External interrupt pin, active low
  output logic            cpu_ce,      // CPU clock enable
  output logic            sram_ce,     // SRAM clock enable
  output logic            tmr_ce,      // Timer/counter clock enable
  output logic            spi_ce,      // SPI clock enable
  output logic            irq_ce,      // Interrupt system clock enable
  output logic            asy_ce,      // Asynchronous timer enable
  output logic            adc_ce,      // ADC clock enable
  output logic            osc_en,      // Main oscillator enable
  output logic            io_ce,       // Other I/O clock enable
  output logic            asleep,      // Device is sleeping
  output logic            wake_pulse   // One cycle at wake-up
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } slpcg_state_t;

  slpcg_state_t st_ff, nxt_st;
  logic [8:0]   ce_ff, nxt_ce;
  logic [2:0]   mode_ff, nxt_mode;
  logic         wake_ff, nxt_wake;
  logic         irq_s1_ff, irq_s2_ff;
  logic [8:0]   dec_ce;
  logic         dec_valid;
  logic         wake_evt;

  slpcg_mode_dec slpcg_mode_dec_inst (
    .mode  (mode_sel),
    .ce    (dec_ce),
    .valid (dec_valid)
  );

  // ****************************************************************
  // Wake event
  // ****************************************************************
  // Pin crosses two flops before use
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
    end else begin
      irq_s1_ff <= ~ext_irq_b;
      irq_s2_ff <= irq_s1_ff;
    end
  end

  // Only interrupts wake; reset wakes via rst_b
  assign wake_evt = irq_pend | irq_s2_ff;

  // ****************************************************************
  // Sleep sequencer
  // ****************************************************************
  always_comb begin
    nxt_st   = st_ff;
    nxt_ce   = ce_ff;
    nxt_mode = mode_ff;
    nxt_wake = 1'b0;
    case (st_ff)
      ST_RUN: begin
        // Undefined mode codes are ignored rather than freezing clocks
        if (sleep_req && sleep_en && dec_valid && !wake_evt) begin
          nxt_st   = ST_SLEEP;
          nxt_ce   = dec_ce;
          nxt_mode = mode_sel;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          nxt_st   = ST_RUN;
          nxt_ce   = slpcg_pkg::CE_ALL_ON;
          nxt_wake = 1'b1;
        end
      end
      default: begin
        nxt_st = ST_RUN;
        nxt_ce = slpcg_pkg::CE_ALL_ON;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_ff   <= ST_RUN;
      ce_ff   <= slpcg_pkg::CE_RST_VAL;
      mode_ff <= slpcg_pkg::MODE_IDLE;
      wake_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      ce_ff   <= nxt_ce;
      mode_ff <= nxt_mode;
      wake_ff <= nxt_wake;
    end
  end

  // ****************************************************************
  // Outputs straight from flops
  // ****************************************************************
  always_comb begin
    cpu_ce     = ce_ff[slpcg_pkg::CE_CPU];
    sram_ce    = ce_ff[slpcg_pkg::CE_SRAM];
    tmr_ce     = ce_ff[slpcg_pkg::CE_TMR];
    spi_ce     = ce_ff[slpcg_pkg::CE_SPI];
    irq_ce     = ce_ff[slpcg_pkg::CE_IRQ];
    asy_ce     = ce_ff[slpcg_pkg::CE_ASY];
    adc_ce     = ce_ff[slpcg_pkg::CE_ADC];
    osc_en     = ce_ff[slpcg_pkg::CE_OSC];
    io_ce      = ce_ff[slpcg_pkg::CE_IO];
    asleep     = st_ff[1];
    wake_pulse = wake_ff;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_enter;
    @(posedge core_clk) disable iff (!rst_b)
      (st_ff == ST_RUN && sleep_req && sleep_en && dec_valid && !wake_evt)
      |=> (asleep && !cpu_ce);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep not entered");

  property p_idle;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && mode_ff == slpcg_pkg::MODE_IDLE)
      |-> (!cpu_ce && sram_ce && tmr_ce && spi_ce && irq_ce);
  endproperty
  a_idle: assert property (p_idle) else $error("idle enables wrong");

  property p_pdown;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && mode_ff == slpcg_pkg::MODE_PWR_DN) |-> (ce_ff == 9'h000);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down not all off");

  property p_psave;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && mode_ff == slpcg_pkg::MODE_PWR_SV) |-> (asy_ce && !osc_en && !cpu_ce);
  endproperty
  a_psave: assert property (p_psave) else $error("power-save enables wrong");

  property p_adcnr;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && mode_ff == slpcg_pkg::MODE_ADC_NR)
      |-> (asy_ce && adc_ce && !cpu_ce && !io_ce && !spi_ce && !tmr_ce);
  endproperty
  a_adcnr: assert property (p_adcnr) else $error("adc noise enables wrong");

  property p_stby;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && mode_ff == slpcg_pkg::MODE_STBY) |-> (osc_en && !asy_ce && !cpu_ce);
  endproperty
  a_stby: assert property (p_stby) else $error("standby enables wrong");

  property p_xstby;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && mode_ff == slpcg_pkg::MODE_EXT_STB) |-> (osc_en && asy_ce && !cpu_ce);
  endproperty
  a_xstby: assert property (p_xstby) else $error("ext standby enables wrong");

  property p_wake;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && wake_evt)
      |=> (!asleep && wake_pulse && ce_ff == slpcg_pkg::CE_ALL_ON) ##1 !wake_pulse;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restore clocks");

  property p_cpu_off;
    @(posedge core_clk) disable iff (!rst_b)
      asleep |-> !cpu_ce;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clock runs asleep");

  // Mode is taken at the request edge, not from later mode_sel changes
  property p_entry_mode;
    @(posedge core_clk) disable iff (!rst_b)
      (st_ff == ST_RUN && nxt_st == ST_SLEEP)
      |=> (asleep && mode_ff == $past(mode_sel));
  endproperty
  a_entry_mode: assert property (p_entry_mode) else $error("wrong mode recorded");

  property p_refuse;
    @(posedge core_clk) disable iff (!rst_b)
      (st_ff == ST_RUN && sleep_req && (!sleep_en || !dec_valid || wake_evt))
      |=> (!asleep && ce_ff == slpcg_pkg::CE_ALL_ON);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused request slept");

  // Only a wake event may leave sleep; late requests must not retarget
  property p_hold;
    @(posedge core_clk) disable iff (!rst_b)
      (asleep && !wake_evt) |=> (asleep && $stable(ce_ff));
  endproperty
  a_hold: assert property (p_hold) else $error("sleep left without wake");

  property p_pulse;
    @(posedge core_clk) disable iff (!rst_b)
      wake_pulse |-> (!asleep && $past(asleep));
  endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse without sleep");

  property p_run;
    @(posedge core_clk) disable iff (!rst_b)
      !asleep |-> (ce_ff == slpcg_pkg::CE_ALL_ON && cpu_ce);
  endproperty
  a_run: assert property (p_run) else $error("clock gated while running");

  // No disable here: this one watches the reset itself
  property p_reset;
    @(posedge core_clk)
      !rst_b |=> (!asleep && !wake_pulse && ce_ff == slpcg_pkg::CE_RST_VAL);
  endproperty
  a_reset: assert property (p_reset) else $error("reset left clocks gated");

endmodule : slpcg_top

// [sim/slpcg_top_tb.sv]
// Self-checking bench for the sleep clock gating controller.
// Assumes slpcg_pkg and slpcg_top are compiled first.
`timescale 1ns/1ps
module slpcg_top_tb;
  logic        core_clk, rst_b, sleep_en, sleep_req, irq_pend, ext_irq_b;
  logic [2:0]  mode_sel;
  logic        cpu_ce, sram_ce, tmr_ce, spi_ce, irq_ce, asy_ce, adc_ce, osc_en, io_ce;
  logic        asleep, wake_pulse;
  typedef struct {int unsigned cyc; logic [10:0] v;} slpcg_note_t;
  slpcg_note_t q[$];
  int unsigned cyc = 0;
  int          num_errors = 0;
  int          n_tests = 0;
  logic [2:0]  modes [6];
  logic [8:0]  ce;
  int unsigned r;
  logic [10:0] seen_v;
  slpcg_note_t head;

  slpcg_top slpcg_top_inst (.core_clk, .rst_b, .sleep_en, .mode_sel, .sleep_req, .irq_pend,
    .ext_irq_b, .cpu_ce, .sram_ce, .tmr_ce, .spi_ce, .irq_ce, .asy_ce, .adc_ce, .osc_en,
    .io_ce, .asleep, .wake_pulse);

  assign seen_v = {asleep, wake_pulse, io_ce, osc_en, adc_ce, asy_ce, irq_ce, spi_ce, tmr_ce,
                   sram_ce, cpu_ce};

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [8:0] exp_ce(input logic [2:0] m);
    case (m)
      slpcg_pkg::MODE_IDLE:   return 9'h1FE;
      slpcg_pkg::MODE_ADC_NR: return 9'h0E0;
      slpcg_pkg::MODE_PWR_DN: return 9'h000;
      slpcg_pkg::MODE_PWR_SV: return 9'h020;
      slpcg_pkg::MODE_STBY:   return 9'h080;
      default:                return 9'h0A0;
    endcase
  endfunction : exp_ce

  task automatic note(input int unsigned ofs, input logic [10:0] v);
    slpcg_note_t n;
    n.cyc = cyc + ofs;
    n.v   = v;
    q.push_back(n);
  endtask : note

  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Clock, monitor, watchdog
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    #1;
    if (q.size() > 0 && q[0].cyc == cyc) begin
      head = q.pop_front();
      check(seen_v, head.v);
    end
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    rst_b = 1'b0; sleep_en = 1'b1; sleep_req = 1'b0; irq_pend = 1'b0; ext_irq_b = 1'b1;
    mode_sel = 3'h0;
    modes = '{slpcg_pkg::MODE_IDLE, slpcg_pkg::MODE_ADC_NR, slpcg_pkg::MODE_PWR_DN,
              slpcg_pkg::MODE_PWR_SV, slpcg_pkg::MODE_STBY, slpcg_pkg::MODE_EXT_STB};
    r = $urandom(32'hC5B3B68E);
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    // Disabled, undefined codes and pending wake must all be ignored
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      sleep_en = (i != 0);
      mode_sel = (i == 1) ? 3'h4 : (i == 2) ? 3'h5 : slpcg_pkg::MODE_PWR_DN;
      irq_pend = (i == 3);
      sleep_req = 1'b1;
      note(1, {2'b00, 9'h1FF});
      @(negedge core_clk);
      sleep_req = 1'b0; irq_pend = 1'b0; sleep_en = 1'b1;
    end
    @(negedge core_clk);
    // Every mode; irq_pend wakes allow the next request right after the pulse
    for (int i = 0; i < 6; i++) begin
      ce = exp_ce(modes[i]);
      mode_sel = modes[i];
      sleep_req = 1'b1;
      note(1, {2'b10, ce});
      @(negedge core_clk);
      sleep_req = 1'($urandom_range(1, 0));
      mode_sel = 3'($urandom_range(7, 0));
      note(1, {2'b10, ce});
      @(negedge core_clk);
      sleep_req = 1'b0;
      repeat ($urandom_range(3, 0)) @(negedge core_clk);
      note(1, {2'b10, ce});
      @(negedge core_clk);
      if (i % 2 == 0) begin
        irq_pend = 1'b1;
        note(1, {2'b01, 9'h1FF});
        @(negedge core_clk);
        irq_pend = 1'b0;
      end else begin
        ext_irq_b = 1'b0;
        note(3, {2'b01, 9'h1FF});
        @(negedge core_clk);
        ext_irq_b = 1'b1;
        // Synchroniser must drain, or the pending pin blocks entry
        repeat (4) @(negedge core_clk);
      end
    end
    // Reset in mid-sleep restores all clocks; request right after release is taken
    sleep_req = 1'b1;
    mode_sel = slpcg_pkg::MODE_PWR_DN;
    note(1, {2'b10, exp_ce(slpcg_pkg::MODE_PWR_DN)});
    @(negedge core_clk);
    sleep_req = 1'b0;
    rst_b = 1'b0;
    note(1, {2'b00, 9'h1FF});
    @(negedge core_clk);
    rst_b = 1'b1;
    sleep_req = 1'b1;
    mode_sel = slpcg_pkg::MODE_STBY;
    note(1, {2'b10, exp_ce(slpcg_pkg::MODE_STBY)});
    @(negedge core_clk);
    sleep_req = 1'b0;
    irq_pend = 1'b1;
    note(1, {2'b01, 9'h1FF});
    @(negedge core_clk);
    irq_pend = 1'b0;
    repeat (3) @(negedge core_clk);
    if (q.size() != 0) num_errors++;
    wrap_up();
  end
endmodule : slpcg_top_tb
